//--- cts_pkg.sv
// Functional notes
// - Three transmit buffers, each a control byte, four id bytes, a length byte, eight data bytes.
// - Before each frame start, the highest-priority queued buffer is chosen.
// - Equal priority goes to the higher buffer index.
// - Two-bit priority field, 11 highest, 00 lowest.
// - Request set by register write, request command or falling edge on request pin.
// - One control byte write sets request and priority together.
// - Setting a request clears abort, lost-arbitration and error flags.
// - Request only marks ready; sending starts when the bus is free.
// - Success clears request, sets done flag, interrupt if enabled.
// - Error keeps request, sets buffer and message error flags, interrupt if enabled.
// - Lost arbitration sets its flag and keeps the request pending.
// - One-shot: single attempt, same flags, request cleared, no retry.
// - Request pins selectable; config register writable only in config mode.
// - Falling edge on an enabled request pin sets that buffer's request.
// - Host clearing a request aborts that buffer without setting abort flag.
// - Abort-all aborts all pending, sets abort flags; host clears it again.
// - A frame already on the bus continues; aborted only if it fails.
// - One-shot failure by error or lost arbitration sets the abort flag.
// - CRC follows data field, or control field for zero data; rx CRC checked.
// - Error counters kept; they select error-active, passive or bus-off.
// - Mode change waits for pending sends; host reads current mode field.
package cts_pkg;
  localparam int CTS_NBUF = 3;
  localparam int CTS_MEM_BYTES = 13;
  localparam int CTS_MEM_DEPTH = 39;
  localparam logic [5:0] CTS_MEM_STRIDE = 6'hD;
  localparam logic [3:0] CTS_BUF_WORDS = 4'hE;
  localparam logic [1:0] CTS_BUF_NONE = 2'h3;
  localparam logic [31:0] CTS_A_CTRL = 32'h0000_0100;
  localparam logic [31:0] CTS_A_STAT = 32'h0000_0104;
  localparam logic [31:0] CTS_A_IEN = 32'h0000_0108;
  localparam logic [31:0] CTS_A_IFLG = 32'h0000_010C;
  localparam logic [31:0] CTS_A_PIN = 32'h0000_0110;
  localparam logic [31:0] CTS_A_RTS = 32'h0000_0114;
  localparam logic [31:0] CTS_A_ERRC = 32'h0000_0118;
  localparam int CTS_B_ABT = 6;
  localparam int CTS_B_LOA = 5;
  localparam int CTS_B_TERR = 4;
  localparam int CTS_B_REQ = 3;
  localparam int CTS_C_ABORT = 4;
  localparam int CTS_C_ONESHOT = 3;
  localparam int CTS_I_MERR = 3;
  localparam logic [2:0] CTS_M_NORMAL = 3'h0;
  localparam logic [2:0] CTS_M_CONFIG = 3'h4;
  localparam logic [3:0] CTS_K_SIDL = 4'h1;
  localparam logic [3:0] CTS_K_DLC = 4'h4;
  localparam int CTS_B_EXT = 3;
  localparam int CTS_B_RTR = 6;
  localparam logic [3:0] CTS_DLC_MAX = 4'h8;
  localparam logic [6:0] CTS_CEND_STD = 7'h13;
  localparam logic [6:0] CTS_CEND_EXT = 7'h27;
  localparam logic [8:0] CTS_TEC_STEP = 9'h008;
  localparam logic [8:0] CTS_TEC_MAX = 9'h1FF;
  localparam logic [7:0] CTS_REC_MAX = 8'hFF;
  localparam logic [1:0] CTS_ES_ACTIVE = 2'h0;
  localparam logic [1:0] CTS_ES_PASSIVE = 2'h1;
  localparam logic [1:0] CTS_ES_BUSOFF = 2'h2;
  typedef struct packed {
    logic bus_idle;
    logic tx_done;
    logic tx_lost;
    logic tx_err;
    logic rx_ok;
    logic rx_err;
  } cts_eng_in_t;
  typedef struct packed {
    logic start;
    logic [1:0] buf_idx;
    logic [103:0] frame;
    logic [6:0] crc_pos;
  } cts_tx_out_t;
  typedef enum logic [1:0] {
    CTS_ST_IDLE = 2'b01,
    CTS_ST_SEND = 2'b10
  } cts_state_t;
endpackage

//--- cts_tx_sched.sv
`timescale 1ns/1ps
`default_nettype none
module cts_tx_sched (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [2:0] tx_request_pin_n,
  input wire cts_pkg::cts_eng_in_t eng_in,
  output var cts_pkg::cts_tx_out_t tx_out,
  output logic irq_n,
  output logic [1:0] err_state
);
  function automatic logic buf_hit(input logic [31:0] a);
    return (a[31:8] == 24'h0) && (a[7:6] != cts_pkg::CTS_BUF_NONE) &&
           (a[5:2] < cts_pkg::CTS_BUF_WORDS) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [5:0] mem_idx(input logic [1:0] b,
                                         input logic [3:0] k);
    return 6'({4'h0, b} * cts_pkg::CTS_MEM_STRIDE + {2'h0, k});
  endfunction

  function automatic logic [6:0] crc_pos_f(input logic ext,
                                           input logic [7:0] len);
    logic [3:0] n;
    n = len[3:0];
    if (len[cts_pkg::CTS_B_RTR])
      n = 4'h0;
    else if (n > cts_pkg::CTS_DLC_MAX)
      n = cts_pkg::CTS_DLC_MAX;
    return (ext ? cts_pkg::CTS_CEND_EXT : cts_pkg::CTS_CEND_STD) +
           {n, 3'h0};
  endfunction

  // Storage and control state
  logic [7:0] mem_reg [0:cts_pkg::CTS_MEM_DEPTH-1];
  logic [2:0] tx_request_bit_reg;
  logic [2:0] tx_request_bit_next;
  logic [1:0] tx_priority_field_reg [0:cts_pkg::CTS_NBUF-1];
  logic [2:0] abort_flag_reg;
  logic [2:0] abort_flag_next;
  logic [2:0] lost_arbitration_flag_reg;
  logic [2:0] lost_arbitration_flag_next;
  logic [2:0] tx_error_flag_reg;
  logic [2:0] tx_error_flag_next;
  logic [2:0] requested_mode_field_reg;
  logic [2:0] current_mode_field_reg;
  logic abort_all_bit_reg;
  logic one_shot_enable_reg;
  logic [3:0] irq_enable_reg;
  logic [3:0] irq_flag_reg;
  logic [3:0] irq_flag_next;
  logic [2:0] request_pin_config_reg;
  logic [2:0] pin_prev_reg;
  logic [8:0] transmit_error_count_reg;
  logic [8:0] transmit_error_count_next;
  logic [7:0] receive_error_count_reg;
  logic [7:0] receive_error_count_next;
  cts_pkg::cts_state_t state_reg;
  cts_pkg::cts_state_t state_next;
  logic [1:0] act_buf_reg;
  logic [1:0] err_state_next;

  // Bus slave state
  logic wr_pend_reg;
  logic [31:0] wr_addr_reg;
  logic rd_pend_reg;
  logic [31:0] rd_addr_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic [31:0] rd_val;

  // Outputs
  cts_pkg::cts_tx_out_t tx_out_reg;
  cts_pkg::cts_tx_out_t tx_out_next;
  logic irq_n_reg;

  // Bus decode
  wire acc = hsel && htrans[1] && hready;
  wire wr_buf = wr_pend_reg && buf_hit(wr_addr_reg);
  wire [1:0] wr_b = wr_addr_reg[7:6];
  wire [3:0] wr_k = wr_addr_reg[5:2];
  wire wr_ctlb = wr_buf && (wr_k == 4'h0);
  wire wr_data = wr_buf && (wr_k != 4'h0);
  wire [5:0] wr_mi = mem_idx(wr_b, wr_k - 4'h1);
  wire wr_ctrl = wr_pend_reg && (wr_addr_reg == cts_pkg::CTS_A_CTRL);
  wire wr_ien = wr_pend_reg && (wr_addr_reg == cts_pkg::CTS_A_IEN);
  wire wr_iflg = wr_pend_reg && (wr_addr_reg == cts_pkg::CTS_A_IFLG);
  wire wr_pin = wr_pend_reg && (wr_addr_reg == cts_pkg::CTS_A_PIN);
  wire wr_rts = wr_pend_reg && (wr_addr_reg == cts_pkg::CTS_A_RTS);
  wire cfg_mode = current_mode_field_reg == cts_pkg::CTS_M_CONFIG;
  wire sending = state_reg == cts_pkg::CTS_ST_SEND;

  // Request sources
  wire [2:0] sel_b = 3'(1) << wr_b;
  wire [2:0] pin_fall = request_pin_config_reg & pin_prev_reg &
                        ~tx_request_pin_n;
  wire [2:0] set_req = ({3{wr_ctlb && hwdata[cts_pkg::CTS_B_REQ]}} & sel_b) |
                       ({3{wr_rts}} & hwdata[2:0]) |
                       pin_fall;
  wire [2:0] clr_host = {3{wr_ctlb && !hwdata[cts_pkg::CTS_B_REQ]}} &
                        sel_b;

  // Outcome of the frame on the bus
  wire [2:0] act_b = sending ? (3'(1) << act_buf_reg) : 3'h0;
  wire [2:0] done_b = act_b & {3{eng_in.tx_done}};
  wire [2:0] lost_b = act_b & {3{eng_in.tx_lost}};
  wire [2:0] err_b = act_b & {3{eng_in.tx_err}};
  wire [2:0] fail_b = lost_b | err_b;
  // Failure drops the request only in one-shot or under abort-all
  wire drop = one_shot_enable_reg || abort_all_bit_reg;
  wire [2:0] drop_b = fail_b & {3{drop}};
  // Frame on the bus is spared; it finishes first
  wire [2:0] abort_all_bit_b = {3{abort_all_bit_reg}} & tx_request_bit_reg &
                      ~act_b;

  // Scheduler pick over queued buffers
  logic [1:0] pick;
  logic pick_ok;
  always_comb begin
    pick = 2'h0;
    pick_ok = 1'b0;
    for (int i = 0; i < cts_pkg::CTS_NBUF; i++) begin
      if (tx_request_bit_reg[i] &&
          (!pick_ok || tx_priority_field_reg[i] >= tx_priority_field_reg[pick]))
      begin
        pick = 2'(i);
        pick_ok = 1'b1;
      end
    end
  end

  wire can_send = (current_mode_field_reg == cts_pkg::CTS_M_NORMAL) &&
                  !abort_all_bit_reg && (err_state != cts_pkg::CTS_ES_BUSOFF);
  wire start = (state_reg == cts_pkg::CTS_ST_IDLE) && pick_ok &&
               can_send && eng_in.bus_idle;
  wire [7:0] sel_sidl = mem_reg[mem_idx(pick, cts_pkg::CTS_K_SIDL)];
  wire [7:0] sel_len = mem_reg[mem_idx(pick, cts_pkg::CTS_K_DLC)];

  // Frame latched for the engine at frame start
  always_comb begin
    tx_out_next = tx_out_reg;
    tx_out_next.start = start;
    if (start) begin
      tx_out_next.buf_idx = pick;
      for (int k = 0; k < cts_pkg::CTS_MEM_BYTES; k++)
        tx_out_next.frame[k*8 +: 8] = mem_reg[mem_idx(pick, 4'(k))];
      tx_out_next.crc_pos = crc_pos_f(sel_sidl[cts_pkg::CTS_B_EXT],
                                      sel_len);
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cts_pkg::CTS_ST_IDLE:
        if (start)
          state_next = cts_pkg::CTS_ST_SEND;
      cts_pkg::CTS_ST_SEND:
        if (eng_in.tx_done || eng_in.tx_lost || eng_in.tx_err)
          state_next = cts_pkg::CTS_ST_IDLE;
      default:
        state_next = cts_pkg::CTS_ST_IDLE;
    endcase
  end

  // Per-buffer request and status flags; a set wins over any clear
  always_comb begin
    for (int i = 0; i < cts_pkg::CTS_NBUF; i++) begin
      tx_request_bit_next[i] = tx_request_bit_reg[i];
      abort_flag_next[i] = abort_flag_reg[i];
      lost_arbitration_flag_next[i] = lost_arbitration_flag_reg[i];
      tx_error_flag_next[i] = tx_error_flag_reg[i];
      if (set_req[i]) begin
        tx_request_bit_next[i] = 1'b1;
        abort_flag_next[i] = 1'b0;
        lost_arbitration_flag_next[i] = 1'b0;
        tx_error_flag_next[i] = 1'b0;
      end else begin
        if (clr_host[i] || done_b[i])
          tx_request_bit_next[i] = 1'b0;
        if (drop_b[i] || abort_all_bit_b[i]) begin
          tx_request_bit_next[i] = 1'b0;
          abort_flag_next[i] = 1'b1;
        end
        if (lost_b[i])
          lost_arbitration_flag_next[i] = 1'b1;
        if (err_b[i])
          tx_error_flag_next[i] = 1'b1;
      end
    end
  end

  // Done and message-error flags, write one to clear
  always_comb begin
    irq_flag_next = irq_flag_reg;
    if (wr_iflg)
      irq_flag_next = irq_flag_reg & ~hwdata[3:0];
    irq_flag_next[2:0] = irq_flag_next[2:0] | done_b;
    if (|err_b)
      irq_flag_next[cts_pkg::CTS_I_MERR] = 1'b1;
  end

  // Fault confinement counters
  always_comb begin
    transmit_error_count_next = transmit_error_count_reg;
    receive_error_count_next = receive_error_count_reg;
    if (cfg_mode) begin
      transmit_error_count_next = 9'h0;
      receive_error_count_next = 8'h0;
    end else begin
      if (|err_b)
        transmit_error_count_next =
          (transmit_error_count_reg > cts_pkg::CTS_TEC_MAX -
           cts_pkg::CTS_TEC_STEP) ? cts_pkg::CTS_TEC_MAX :
          transmit_error_count_reg + cts_pkg::CTS_TEC_STEP;
      else if (|done_b && transmit_error_count_reg != 9'h0)
        transmit_error_count_next = transmit_error_count_reg - 9'h1;
      // Bad received CRC arrives as a receive error
      if (eng_in.rx_err &&
          receive_error_count_reg != cts_pkg::CTS_REC_MAX)
        receive_error_count_next = receive_error_count_reg + 8'h1;
      else if (eng_in.rx_ok && receive_error_count_reg != 8'h0)
        receive_error_count_next = receive_error_count_reg - 8'h1;
    end
  end

  always_comb begin
    if (transmit_error_count_next[8])
      err_state_next = cts_pkg::CTS_ES_BUSOFF;
    else if (transmit_error_count_next[7] || receive_error_count_next[7])
      err_state_next = cts_pkg::CTS_ES_PASSIVE;
    else
      err_state_next = cts_pkg::CTS_ES_ACTIVE;
  end

  // Register read mux
  always_comb begin
    rd_val = 32'h0;
    if (buf_hit(rd_addr_reg)) begin
      if (rd_addr_reg[5:2] == 4'h0) begin
        rd_val[cts_pkg::CTS_B_ABT] = abort_flag_reg[rd_addr_reg[7:6]];
        rd_val[cts_pkg::CTS_B_LOA] =
          lost_arbitration_flag_reg[rd_addr_reg[7:6]];
        rd_val[cts_pkg::CTS_B_TERR] = tx_error_flag_reg[rd_addr_reg[7:6]];
        rd_val[cts_pkg::CTS_B_REQ] = tx_request_bit_reg[rd_addr_reg[7:6]];
        rd_val[1:0] = tx_priority_field_reg[rd_addr_reg[7:6]];
      end else begin
        rd_val[7:0] = mem_reg[mem_idx(rd_addr_reg[7:6],
                                      rd_addr_reg[5:2] - 4'h1)];
      end
    end else begin
      case (rd_addr_reg)
        cts_pkg::CTS_A_CTRL:
          rd_val[7:0] = {requested_mode_field_reg, abort_all_bit_reg,
                         one_shot_enable_reg, 3'h0};
        cts_pkg::CTS_A_STAT:
          rd_val[7:0] = {current_mode_field_reg, 2'h0, err_state,
                         sending};
        cts_pkg::CTS_A_IEN:
          rd_val[3:0] = irq_enable_reg;
        cts_pkg::CTS_A_IFLG:
          rd_val[3:0] = irq_flag_reg;
        cts_pkg::CTS_A_PIN:
          rd_val[5:0] = {tx_request_pin_n, request_pin_config_reg};
        cts_pkg::CTS_A_ERRC:
          rd_val[23:0] = {receive_error_count_reg, 7'h0,
                          transmit_error_count_reg};
        default:
          rd_val = 32'h0;
      endcase
    end
  end

  // Bus slave: writes take no wait, reads one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 32'h0;
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= 32'h0;
      hrdata_reg <= 32'h0;
      hreadyout_reg <= 1'b1;
    end else begin
      wr_pend_reg <= acc && hwrite;
      if (acc)
        wr_addr_reg <= haddr;
      if (acc && !hwrite)
        rd_addr_reg <= haddr;
      rd_pend_reg <= acc && !hwrite;
      hreadyout_reg <= !(acc && !hwrite);
      if (rd_pend_reg)
        hrdata_reg <= rd_val;
    end
  end

  always_ff @(posedge hclk) begin
    if (wr_data)
      mem_reg[wr_mi] <= hwdata[7:0];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < cts_pkg::CTS_NBUF; i++)
        tx_priority_field_reg[i] <= 2'h0;
    end else if (wr_ctlb) begin
      tx_priority_field_reg[wr_b] <= hwdata[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_request_bit_reg <= 3'h0;
      abort_flag_reg <= 3'h0;
      lost_arbitration_flag_reg <= 3'h0;
      tx_error_flag_reg <= 3'h0;
      irq_flag_reg <= 4'h0;
      state_reg <= cts_pkg::CTS_ST_IDLE;
      act_buf_reg <= 2'h0;
      tx_out_reg <= '0;
    end else begin
      tx_request_bit_reg <= tx_request_bit_next;
      abort_flag_reg <= abort_flag_next;
      lost_arbitration_flag_reg <= lost_arbitration_flag_next;
      tx_error_flag_reg <= tx_error_flag_next;
      irq_flag_reg <= irq_flag_next;
      state_reg <= state_next;
      if (start)
        act_buf_reg <= pick;
      tx_out_reg <= tx_out_next;
    end
  end

  // Control, mode and pin configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      requested_mode_field_reg <= cts_pkg::CTS_M_CONFIG;
      current_mode_field_reg <= cts_pkg::CTS_M_CONFIG;
      abort_all_bit_reg <= 1'b0;
      one_shot_enable_reg <= 1'b0;
      irq_enable_reg <= 4'h0;
      request_pin_config_reg <= 3'h0;
      pin_prev_reg <= 3'h7;
    end else begin
      if (wr_ctrl) begin
        requested_mode_field_reg <= hwdata[7:5];
        abort_all_bit_reg <= hwdata[cts_pkg::CTS_C_ABORT];
        one_shot_enable_reg <= hwdata[cts_pkg::CTS_C_ONESHOT];
      end
      // Holds off until nothing is queued or on the bus
      if (!(|tx_request_bit_reg) && !sending)
        current_mode_field_reg <= requested_mode_field_reg;
      if (wr_ien)
        irq_enable_reg <= hwdata[3:0];
      if (wr_pin && cfg_mode)
        request_pin_config_reg <= hwdata[2:0];
      pin_prev_reg <= tx_request_pin_n;
    end
  end

  // Counters and derived outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      transmit_error_count_reg <= 9'h0;
      receive_error_count_reg <= 8'h0;
      err_state <= cts_pkg::CTS_ES_ACTIVE;
      irq_n_reg <= 1'b1;
    end else begin
      transmit_error_count_reg <= transmit_error_count_next;
      receive_error_count_reg <= receive_error_count_next;
      err_state <= err_state_next;
      irq_n_reg <= !(|(irq_flag_next & irq_enable_reg));
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = 1'b0;
  assign tx_out = tx_out_reg;
  assign irq_n = irq_n_reg;
endmodule // cts_tx_sched
`default_nettype wire

//--- cts_tx_sched_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cts_tx_sched_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire cts_pkg::cts_eng_in_t eng_in,
  input wire cts_pkg::cts_tx_out_t tx_out,
  input wire logic [1:0] err_state
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  wire take = hsel && htrans[1] && hready;
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("bus response not OKAY");
  read_wait_a: assert property (
    take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled the bus");
  // Outcome needs a cycle, so two quiet cycles follow any start
  start_pulse_a: assert property (
    tx_out.start |=> !tx_out.start [*2])
    else $error("start pulse too long or too close");
  start_idle_a: assert property (
    tx_out.start |-> $past(eng_in.bus_idle))
    else $error("start taken on a busy bus");
  crc_place_a: assert property (tx_out.start |->
    (tx_out.crc_pos[2:0] == 3'h3 && tx_out.crc_pos inside {[7'h13:7'h53]})
    || (tx_out.crc_pos[2:0] == 3'h7 && tx_out.crc_pos inside {[7'h27:7'h67]}))
    else $error("CRC position off a field boundary");
  buf_legal_a: assert property (
    tx_out.start |-> tx_out.buf_idx != cts_pkg::CTS_BUF_NONE)
    else $error("start names no buffer");
  err_legal_a: assert property (err_state != 2'h3)
    else $error("undefined error state");
endmodule // cts_tx_sched_monitor
bind cts_tx_sched cts_tx_sched_monitor i_cts_tx_sched_monitor (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .eng_in(eng_in), .tx_out(tx_out),
  .err_state(err_state));
`default_nettype wire

//--- cts_eng_model.sv
`timescale 1ns/1ps
`default_nettype none
// Engine stand-in: one outcome pulse per start, after a set delay
module cts_eng_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire cts_pkg::cts_tx_out_t tx_out,
  input wire logic bus_free,
  input wire logic [1:0] outcome,
  input wire logic [7:0] delay,
  input wire logic [1:0] rx_evt,
  output var cts_pkg::cts_eng_in_t eng_in
);
  logic busy_reg;
  logic [7:0] cnt_reg;
  wire fin = busy_reg && (cnt_reg == 8'h00);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_reg <= 1'b0;
      cnt_reg <= 8'h00;
    end else if (tx_out.start) begin
      busy_reg <= 1'b1;
      cnt_reg <= delay;
    end else if (fin) begin
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
  // Own frame keeps the bus busy; receive outcomes come from the bench
  always_comb begin
    eng_in = '0;
    eng_in.rx_ok = rx_evt[0];
    eng_in.rx_err = rx_evt[1];
    eng_in.bus_idle = bus_free && !busy_reg;
    eng_in.tx_done = fin && (outcome == 2'h0);
    eng_in.tx_lost = fin && (outcome == 2'h1);
    eng_in.tx_err = fin && (outcome == 2'h2);
  end
endmodule // cts_eng_model
`default_nettype wire

//--- tb_can_transmit_buffer_scheduler.sv
`timescale 1ns/1ps
`default_nettype none
module tb_can_transmit_buffer_scheduler;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
  logic bus_free = 1'b0, hreadyout, hresp, irq_n;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0, outcome = 2'h0, err_state;
  logic [2:0] hsize = 3'h2, tx_request_pin_n = 3'h7;
  logic [7:0] delay = 8'h03;
  logic [1:0] rx_evt = 2'h0;
  cts_pkg::cts_eng_in_t eng_in;
  cts_pkg::cts_tx_out_t tx_out;
  logic [6:0] crc_e [3] = '{7'h13, 7'h67, 7'h53};
  logic [31:0] frm_e [3] = '{32'h00C3_5A00, 32'h08C3_5A08, 32'h0FC3_5A00};
  int mismatches = 0, check_count = 0;
  always #2.5 hclk = ~hclk;
  cts_tx_sched i_cts_tx_sched (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .tx_request_pin_n(tx_request_pin_n), .eng_in(eng_in),
    .tx_out(tx_out), .irq_n(irq_n), .err_state(err_state));
  cts_eng_model i_cts_eng_model (
    .hclk(hclk), .hresetn(hresetn), .tx_out(tx_out), .bus_free(bus_free),
    .outcome(outcome), .delay(delay), .rx_evt(rx_evt), .eng_in(eng_in));
  function automatic logic [31:0] ba(input int b, input int k);
    return 32'(b * 64 + k * 4);
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rc(input logic [31:0] a, m, e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask
  task automatic ld(input int b, input logic [7:0] sidl, n);
    rc(ba(b, 0), 32'h8, 32'h0);
    wr(ba(b, 1), 32'hA0 | 32'(b));
    wr(ba(b, 2), 32'(sidl));
    wr(ba(b, 3), 32'h5A);
    wr(ba(b, 4), 32'hC3);
    wr(ba(b, 5), 32'(n));
  endtask
  task automatic wait_start(input logic [1:0] eb);
    repeat (400) begin
      @(posedge hclk);
      if (tx_out.start === 1'b1) break;
    end
    chk(32'(tx_out.start), 32'h1);
    chk(32'(tx_out.buf_idx), 32'(eb));
    chk(32'(tx_out.crc_pos), 32'(crc_e[eb]));
    chk(32'(tx_out.frame[7:0]), 32'hA0 | 32'(eb));
    chk(32'(tx_out.frame[39:8]), frm_e[eb]);
  endtask
  task automatic wait_end();
    repeat (400) begin
      @(posedge hclk);
      if (eng_in.tx_done | eng_in.tx_lost | eng_in.tx_err) break;
    end
    @(posedge hclk);
  endtask
  task automatic no_start(input int n);
    repeat (n) begin
      @(posedge hclk);
      chk(32'(tx_out.start), 32'h0);
    end
  endtask
  // One receive outcome pulse, then the receive count is read back
  task automatic rx_one(input logic [1:0] v, input logic [31:0] e);
    rx_evt <= v;
    @(posedge hclk);
    rx_evt <= 2'h0;
    rc(cts_pkg::CTS_A_ERRC, 32'hFF_0000, e);
  endtask
  // Bus held busy after our start so the outcome can be inspected
  task automatic one(input logic [1:0] eb);
    bus_free <= 1'b1;
    wait_start(eb);
    bus_free <= 1'b0;
    wait_end();
  endtask
  task automatic t_regs();
    rc(cts_pkg::CTS_A_STAT, 32'hFF, 32'h80);
    wr(cts_pkg::CTS_A_PIN, 32'h7);
    rc(cts_pkg::CTS_A_PIN, 32'h3F, 32'h3F);
    rc(32'h200, 32'hFFFF_FFFF, 32'h0);
    wr(cts_pkg::CTS_A_CTRL, 32'h0);
    rc(cts_pkg::CTS_A_STAT, 32'hE1, 32'h0);
    wr(cts_pkg::CTS_A_PIN, 32'h0);
    rc(cts_pkg::CTS_A_PIN, 32'h7, 32'h7);
    wr(cts_pkg::CTS_A_IEN, 32'hF);
    ld(0, 8'h00, 8'h00);
    ld(1, 8'h08, 8'h08);
    ld(2, 8'h00, 8'h0F);
    $display("t_regs done");
  endtask
  task automatic t_prio(input logic [5:0] p, o);
    bus_free <= 1'b0;
    outcome <= 2'h0;
    for (int b = 0; b < 3; b++) wr(ba(b, 0), 32'(p[2*b +: 2]) | 32'h8);
    bus_free <= 1'b1;
    for (int i = 0; i < 3; i++) wait_start(o[2*i +: 2]);
    wait_end();
    for (int b = 0; b < 3; b++) rc(ba(b, 0), 32'hFF, 32'(p[2*b +: 2]));
    rc(cts_pkg::CTS_A_IFLG, 32'hF, 32'h7);
    chk(32'(irq_n), 32'h0);
    wr(cts_pkg::CTS_A_IFLG, 32'hF);
    @(posedge hclk);
    chk(32'(irq_n), 32'h1);
    $display("t_prio done");
  endtask
  task automatic t_fail();
    outcome <= 2'h1;
    wr(ba(2, 0), 32'hB);
    one(2'h2);
    rc(ba(2, 0), 32'h7B, 32'h2B);
    outcome <= 2'h2;
    one(2'h2);
    rc(ba(2, 0), 32'h5B, 32'h1B);
    rc(cts_pkg::CTS_A_IFLG, 32'hF, 32'h8);
    chk(32'(irq_n), 32'h0);
    rc(cts_pkg::CTS_A_ERRC, 32'h1FF, 32'h8);
    rx_one(2'h2, 32'h1_0000);
    rx_one(2'h1, 32'h0);
    chk(32'(err_state), 32'(cts_pkg::CTS_ES_ACTIVE));
    wr(ba(2, 0), 32'hB);
    rc(ba(2, 0), 32'h7B, 32'hB);
    wr(ba(2, 0), 32'h3);
    rc(ba(2, 0), 32'h7B, 32'h3);
    wr(cts_pkg::CTS_A_IFLG, 32'hF);
    wr(cts_pkg::CTS_A_CTRL, 32'h8);
    outcome <= 2'h1;
    wr(ba(1, 0), 32'h9);
    one(2'h1);
    bus_free <= 1'b1;
    no_start(30);
    rc(ba(1, 0), 32'h7B, 32'h61);
    wr(cts_pkg::CTS_A_CTRL, 32'h0);
    $display("t_fail done");
  endtask
  task automatic t_abort();
    outcome <= 2'h2;
    delay <= 8'h28;
    wr(ba(0, 0), 32'hB);
    wait_start(2'h0);
    wr(ba(1, 0), 32'h8);
    wr(cts_pkg::CTS_A_CTRL, 32'h10);
    rc(ba(1, 0), 32'h48, 32'h40);
    wait_end();
    no_start(20);
    rc(ba(0, 0), 32'h48, 32'h40);
    outcome <= 2'h0;
    delay <= 8'h03;
    wr(cts_pkg::CTS_A_CTRL, 32'h0);
    wr(ba(1, 0), 32'h8);
    wait_start(2'h1);
    wait_end();
    wr(cts_pkg::CTS_A_IFLG, 32'hF);
    $display("t_abort done");
  endtask
  task automatic t_pin();
    tx_request_pin_n <= 3'h6;
    wait_start(2'h0);
    tx_request_pin_n <= 3'h7;
    wait_end();
    wr(cts_pkg::CTS_A_RTS, 32'h4);
    wait_start(2'h2);
    wait_end();
    rc(cts_pkg::CTS_A_RTS, 32'hFF, 32'h0);
    $display("t_pin done");
  endtask
  task automatic t_mode();
    bus_free <= 1'b0;
    wr(ba(0, 0), 32'h8);
    wr(cts_pkg::CTS_A_CTRL, 32'h80);
    rc(cts_pkg::CTS_A_STAT, 32'hE0, 32'h0);
    wr(ba(0, 0), 32'h0);
    rc(cts_pkg::CTS_A_STAT, 32'hE0, 32'h80);
    rc(cts_pkg::CTS_A_ERRC, 32'hFF01FF, 32'h0);
    $display("t_mode done");
  endtask
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_prio(6'h17, 6'h18);
    t_prio(6'h22, 6'h12);
    t_prio(6'h3F, 6'h06);
    t_fail();
    t_abort();
    t_pin();
    t_mode();
    test_done();
  end
  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    test_done();
  end
endmodule // tb_can_transmit_buffer_scheduler
`default_nettype wire
